// ==== design/pdseq_consts.svh ====
// register offsets, field positions, reset values and timing figures
// assumes a 20 MHz core clock and an 8-bit register port
`ifndef PDSEQ_CONSTS_SVH
`define PDSEQ_CONSTS_SVH

// register offsets on the 4-bit register port
`define OFS_POWER_CONTROL      4'h0
`define OFS_POWER_CONTROL_TWO  4'h1
`define OFS_SYSTEM_CONTROL     4'h2
`define OFS_DISPLAY_CONTROL    4'h3
`define OFS_RTC_CONTROL        4'h4
`define OFS_STATUS             4'h5

// field positions
`define BIT_ARM                1
`define BIT_START              6
`define BIT_WAKE_ENABLE        7
`define BIT_WAKE_SOURCE        4
`define BIT_MAP_SELECT         4
`define BIT_DISPLAY_ENABLE     0
`define BIT_DISPLAY_CLK_SEL    1
`define BIT_RTC_IRQ_ENABLE     0
`define BIT_RTC_IRQ_FLAG       1
`define BIT_RTC_POWER_DOWN     3

// reset values
`define RST_BYTE               8'h00
`define RST_RTC_CONTROL        8'h08

// writable bits of the power control register besides arm and start
`define POWER_CONTROL_REG_STORE_MASK        8'hBD

// wake-up vector shown to the cpu
`define WAKE_VECTOR            16'h007B

// timing: clock period and wake pin low time, both in ns
`define CLK_PERIOD_NS          50
`define WAKE_LOW_NS            10000
`define WAKE_LOW_CLKS          ((`WAKE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// machine cycle length and interrupt call length
`define MCYCLE_CLKS            12
`define CALL_MCYCLES           2

`endif

// ==== design/pdseq_pkg.sv ====
// types shared by the power-down sequencer files
// assumes nothing beyond a SystemVerilog compiler
package pdseq_pkg;

    // sequencer phases
    typedef enum logic [2:0] {
        ST_RUN  = 3'b000,
        ST_DOWN = 3'b001,
        ST_OSC  = 3'b010,
        ST_CALL = 3'b011,
        ST_ISR  = 3'b100
    } seq_state_t;

    // power-down flavour chosen at entry
    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_ONE  = 2'b01,
        MODE_TWO  = 2'b10,
        MODE_THREE = 2'b11
    } pd_mode_t;

endpackage : pdseq_pkg

// ==== design/wake_filter.sv ====
// low-level qualifier for the wake pin
// assumes the pin is synchronous to clk_i
`timescale 1ns/1ps
module wake_filter #(
    parameter int CNT = 200
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // qualifier
    input  wire logic arm_i,
    input  wire logic low_i,
    output logic      wake_o
);
    logic [$clog2(CNT+1)-1:0] count_r;

    // count consecutive low cycles, pulse once when the time is reached
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_r <= '0;
        end else if (!arm_i || !low_i) begin
            count_r <= '0;
        end else if (count_r != CNT[$bits(count_r)-1:0]) begin
            count_r <= count_r + 1'b1;
        end
    end

    assign wake_o = arm_i && low_i && (count_r == CNT[$bits(count_r)-1:0] - 1'b1);
endmodule : wake_filter

// ==== design/mcycle_div.sv ====
// machine-cycle tick divider
// assumes one tick per N core clocks is wanted while enabled
`timescale 1ns/1ps
module mcycle_div #(
    parameter int N = 12
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // control and tick
    input  wire logic en_i,
    output logic      tick_o
);
    logic [$clog2(N)-1:0] div_r;

    // free count restarted whenever disabled
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_r <= '0;
        end else if (!en_i || div_r == N[$bits(div_r)-1:0] - 1'b1) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    assign tick_o = en_i && (div_r == N[$bits(div_r)-1:0] - 1'b1);
endmodule : mcycle_div

// ==== design/power_down_sequencer.sv ====
// power-down entry, wake-up phases and pin states of an 8-bit controller
// assumes a cpu that halts on cpu_halt_o and signals its return from the
// wake-up routine on wake_return_i; all inputs synchronous to clk_i
`timescale 1ns/1ps
`include "pdseq_consts.svh"
module power_down_sequencer #(
    parameter int WAKE_CNT   = `WAKE_LOW_CLKS,
    parameter int MCYCLE     = `MCYCLE_CLKS
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [7:0]       rd_data_o,
    // wake sources and cpu status
    input  wire logic        wake_pin_i,
    input  wire logic        wake_latch_i,
    input  wire logic        rtc_event_i,
    input  wire logic        osc_stable_i,
    input  wire logic        wake_return_i,
    input  wire logic        idle_i,
    input  wire logic        ext_code_i,
    input  wire logic        cpu_ale_i,
    input  wire logic        cpu_strobe_i,
    // cpu control
    output logic             cpu_halt_o,
    output logic             irq_mask_o,
    output logic             periph_freeze_o,
    output logic             wake_irq_o,
    output logic [15:0]      wake_vector_o,
    output logic             fetch_discard_o,
    // clocks and units
    output logic             osc_run_o,
    output logic             rtc_run_o,
    output logic             display_run_o,
    // pins
    output logic             ale_o,
    output logic             program_strobe_output_o,
    output logic             port0_float_o,
    output logic             display_hold_o,
    output logic             display_off_o
);
    pdseq_pkg::seq_state_t state_r, state_nxt;
    pdseq_pkg::pd_mode_t   mode_r, mode_nxt;

    logic [7:0] power_control_reg_r;
    logic       wake_enable_r, wake_source_select_r, register_map_select_r;
    logic       display_enable_r, display_clock_select_r;
    logic       rtc_power_down_r, rtc_interrupt_enable_r, rtc_interrupt_flag_r;
    logic       armed_r, wake_en_entry_r, src_rtc_entry_r;
    logic [7:0] rd_data_r;
    logic       ale_r, strobe_r, float_r;
    logic [1:0] call_cnt_r;
    logic       wr_power_control_reg, arm_wr, start_wr, entry_now;
    logic       pin_wake, rtc_wake, wake_req, mtick;

    // register decode
    assign wr_power_control_reg   = wr_i && addr_i == `OFS_POWER_CONTROL;
    assign arm_wr    = wr_power_control_reg && wr_data_i[`BIT_ARM] && !wr_data_i[`BIT_START];
    assign start_wr  = wr_power_control_reg && wr_data_i[`BIT_START] && !wr_data_i[`BIT_ARM];
    assign entry_now = start_wr && armed_r && state_r == pdseq_pkg::ST_RUN;

    // arm held for exactly the next power control write
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed_r <= 1'b0;
        end else if (wr_power_control_reg) begin
            armed_r <= arm_wr;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            power_control_reg_r <= `RST_BYTE;
        end else if (wr_power_control_reg) begin
            power_control_reg_r <= wr_data_i & `POWER_CONTROL_REG_STORE_MASK;
        end
    end

    // second power register writable only with map select, readable always
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_enable_r        <= 1'b0;
            wake_source_select_r <= 1'b0;
        end else if (wr_i && addr_i == `OFS_POWER_CONTROL_TWO && register_map_select_r) begin
            wake_enable_r        <= wr_data_i[`BIT_WAKE_ENABLE];
            wake_source_select_r <= wr_data_i[`BIT_WAKE_SOURCE];
        end
    end

    // system, display and clock control bits
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            register_map_select_r  <= 1'b0;
            display_enable_r       <= 1'b0;
            display_clock_select_r <= 1'b0;
            rtc_power_down_r       <= 1'(`RST_RTC_CONTROL >> `BIT_RTC_POWER_DOWN);
            rtc_interrupt_enable_r <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == `OFS_SYSTEM_CONTROL) begin
                register_map_select_r <= wr_data_i[`BIT_MAP_SELECT];
            end
            if (addr_i == `OFS_DISPLAY_CONTROL) begin
                display_enable_r       <= wr_data_i[`BIT_DISPLAY_ENABLE];
                display_clock_select_r <= wr_data_i[`BIT_DISPLAY_CLK_SEL];
            end
            if (addr_i == `OFS_RTC_CONTROL) begin
                rtc_power_down_r       <= wr_data_i[`BIT_RTC_POWER_DOWN];
                rtc_interrupt_enable_r <= wr_data_i[`BIT_RTC_IRQ_ENABLE];
            end
        end
    end

    // flag set by clock event, cleared by writing zero, set wins
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rtc_interrupt_flag_r <= 1'b0;
        end else if (rtc_event_i && !rtc_power_down_r) begin
            rtc_interrupt_flag_r <= 1'b1;
        end else if (wr_i && addr_i == `OFS_RTC_CONTROL && !wr_data_i[`BIT_RTC_IRQ_FLAG]) begin
            rtc_interrupt_flag_r <= 1'b0;
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_r <= `RST_BYTE;
        end else if (rd_i) begin
            unique case (addr_i)
                `OFS_POWER_CONTROL:     rd_data_r <= power_control_reg_r;
                `OFS_POWER_CONTROL_TWO: rd_data_r <= {wake_enable_r, 2'b00,
                                                      wake_source_select_r, 4'h0};
                `OFS_SYSTEM_CONTROL:    rd_data_r <= {3'b000, register_map_select_r, 4'h0};
                `OFS_DISPLAY_CONTROL:   rd_data_r <= {6'h00, display_clock_select_r,
                                                      display_enable_r};
                `OFS_RTC_CONTROL:       rd_data_r <= {4'h0, rtc_power_down_r, 1'b0,
                                                      rtc_interrupt_flag_r,
                                                      rtc_interrupt_enable_r};
                `OFS_STATUS:            rd_data_r <= {1'b0, mode_r, wake_en_entry_r,
                                                      1'b0, state_r};
                default:                rd_data_r <= `RST_BYTE;
            endcase
        end
    end
    assign rd_data_o = rd_data_r;

    // mode chosen from display and clock settings at entry
    always_comb begin
        mode_nxt = pdseq_pkg::MODE_ONE;
        if (!rtc_power_down_r && display_enable_r && display_clock_select_r) begin
            mode_nxt = pdseq_pkg::MODE_TWO;
        end else if (!rtc_power_down_r && !display_enable_r) begin
            mode_nxt = pdseq_pkg::MODE_THREE;
        end
    end

    // wake enable and source captured at entry
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r          <= pdseq_pkg::MODE_NONE;
            wake_en_entry_r <= 1'b0;
            src_rtc_entry_r <= 1'b0;
        end else if (entry_now) begin
            mode_r          <= mode_nxt;
            wake_en_entry_r <= wake_enable_r;
            // mode one ignores the source select
            src_rtc_entry_r <= wake_source_select_r && mode_nxt != pdseq_pkg::MODE_ONE;
        end else if (state_r == pdseq_pkg::ST_RUN) begin
            mode_r          <= pdseq_pkg::MODE_NONE;
        end
    end

    // pin low for the qualifying time
    wake_filter #(
        .CNT      (WAKE_CNT)
    ) u_wake_filter (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .arm_i    (state_r == pdseq_pkg::ST_DOWN && wake_en_entry_r && !src_rtc_entry_r),
        .low_i    (!wake_pin_i),
        .wake_o   (pin_wake)
    );

    // machine cycles for the interrupt call
    mcycle_div #(
        .N        (MCYCLE)
    ) u_mcycle_div (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .en_i     (state_r == pdseq_pkg::ST_CALL),
        .tick_o   (mtick)
    );

    // clock wake counted only in power-down
    // needs wake enable, clock interrupt enable and source select
    assign rtc_wake = state_r == pdseq_pkg::ST_DOWN && wake_en_entry_r && src_rtc_entry_r
                      && rtc_interrupt_enable_r && rtc_event_i;
    // latch bit not one wakes at once
    // no wake unless enabled at entry
    assign wake_req = pin_wake || rtc_wake ||
                      (state_r == pdseq_pkg::ST_DOWN && wake_en_entry_r && !src_rtc_entry_r
                       && !wake_latch_i);

    // phase sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pdseq_pkg::ST_RUN:  if (entry_now) state_nxt = pdseq_pkg::ST_DOWN;
            pdseq_pkg::ST_DOWN: if (wake_req) state_nxt = pdseq_pkg::ST_OSC;
            pdseq_pkg::ST_OSC:  if (osc_stable_i) state_nxt = pdseq_pkg::ST_CALL;
            pdseq_pkg::ST_CALL: begin
                if (mtick && call_cnt_r == 2'(`CALL_MCYCLES - 1)) begin
                    state_nxt = pdseq_pkg::ST_ISR;
                end
            end
            // phase four ends on the routine's return
            pdseq_pkg::ST_ISR:  if (wake_return_i) state_nxt = pdseq_pkg::ST_RUN;
            default:            state_nxt = pdseq_pkg::ST_RUN;
        endcase
    end

    // reset returns to run with oscillators on
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= pdseq_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // machine cycles elapsed in the call
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            call_cnt_r <= 2'b00;
        end else if (state_r != pdseq_pkg::ST_CALL) begin
            call_cnt_r <= 2'b00;
        end else if (mtick) begin
            call_cnt_r <= call_cnt_r + 2'b01;
        end
    end

    // halt in the very cycle of the start write
    assign cpu_halt_o      = entry_now || state_r == pdseq_pkg::ST_DOWN ||
                             state_r == pdseq_pkg::ST_OSC;
    // mask from phase two to end of phase four
    assign irq_mask_o      = state_r == pdseq_pkg::ST_OSC || state_r == pdseq_pkg::ST_CALL ||
                             state_r == pdseq_pkg::ST_ISR;
    // timers and watchdog frozen until phase four ends
    assign periph_freeze_o = state_r != pdseq_pkg::ST_RUN;
    // wake interrupt raised as the call begins
    assign wake_irq_o      = state_r == pdseq_pkg::ST_OSC && osc_stable_i;
    assign wake_vector_o   = `WAKE_VECTOR;
    assign fetch_discard_o = state_r == pdseq_pkg::ST_CALL;

    assign osc_run_o     = state_r != pdseq_pkg::ST_DOWN;
    assign rtc_run_o     = !rtc_power_down_r &&
                           !(state_r == pdseq_pkg::ST_DOWN && mode_r == pdseq_pkg::MODE_ONE);
    assign display_run_o = display_enable_r &&
                           (state_r == pdseq_pkg::ST_RUN || mode_r == pdseq_pkg::MODE_TWO);
    // display pins keep driving in mode two
    assign display_hold_o = state_r != pdseq_pkg::ST_RUN && mode_r == pdseq_pkg::MODE_TWO;
    assign display_off_o  = state_r != pdseq_pkg::ST_RUN && mode_r == pdseq_pkg::MODE_THREE;

    // idle high, power-down low, cpu drive otherwise
    // low held until the call starts
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ale_r    <= 1'b1;
            strobe_r <= 1'b1;
            float_r  <= 1'b0;
        end else if (state_nxt == pdseq_pkg::ST_DOWN || state_nxt == pdseq_pkg::ST_OSC) begin
            ale_r    <= 1'b0;
            strobe_r <= 1'b0;
            float_r  <= ext_code_i;
        end else if (state_nxt == pdseq_pkg::ST_RUN && idle_i) begin
            ale_r    <= 1'b1;
            strobe_r <= 1'b1;
            float_r  <= ext_code_i;
        end else begin
            ale_r    <= cpu_ale_i;
            strobe_r <= cpu_strobe_i;
            float_r  <= 1'b0;
        end
    end
    assign ale_o                   = ale_r;
    assign program_strobe_output_o = strobe_r;
    assign port0_float_o           = float_r;

    // checks
    property p_no_dual;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_r == pdseq_pkg::ST_RUN && wr_power_control_reg && wr_data_i[`BIT_ARM]
         && wr_data_i[`BIT_START]) |=> state_r == pdseq_pkg::ST_RUN;
    endproperty
    AST_NO_DUAL_ENTRY: assert property (p_no_dual)
        else $error("entry on combined arm and start");
    AST_TWO_WRITE_ENTRY: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == pdseq_pkg::ST_RUN && arm_wr) ##1 start_wr |=> state_r == pdseq_pkg::ST_DOWN)
        else $error("two-write sequence did not enter");
    AST_READ_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == `OFS_POWER_CONTROL) |=> !rd_data_o[`BIT_ARM] && !rd_data_o[`BIT_START])
        else $error("arm or start read back set");
    AST_HALT_AT_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
        entry_now |-> cpu_halt_o ##1 cpu_halt_o)
        else $error("cpu not halted at start write");
    AST_RESET_ONLY: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == pdseq_pkg::ST_DOWN && !wake_en_entry_r) |=> state_r == pdseq_pkg::ST_DOWN)
        else $error("woke with wake disabled");
    AST_PIN_TIME: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == pdseq_pkg::ST_DOWN && pin_wake) |-> !wake_pin_i && !$past(wake_pin_i)
         && !$past(wake_pin_i, 2))
        else $error("pin wake without low pin");
    AST_MASK_PHASES: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(state_r == pdseq_pkg::ST_OSC) |-> irq_mask_o ##1 irq_mask_o
        ##1 irq_mask_o)
        else $error("interrupts not masked in wake phase");
    AST_CALL_LEN: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(state_r == pdseq_pkg::ST_CALL) |-> ##[23:25] state_r == pdseq_pkg::ST_ISR)
        else $error("interrupt call length wrong");
    AST_RTC_NO_EFFECT: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == pdseq_pkg::ST_RUN && !entry_now) |=> state_r == pdseq_pkg::ST_RUN)
        else $error("left run without entry");
    AST_PINS_LOW: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == pdseq_pkg::ST_DOWN) [*2] |-> !ale_o && !program_strobe_output_o)
        else $error("strobes not low in power-down");
    AST_FREEZE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == pdseq_pkg::ST_ISR && !wake_return_i) |=> periph_freeze_o)
        else $error("timers released before phase four ends");
    COV_ENTRY: cover property (@(posedge clk_i) disable iff (!resetn_i) entry_now);
    COV_PIN_WAKE: cover property (@(posedge clk_i) disable iff (!resetn_i)
        pin_wake ##1 state_r == pdseq_pkg::ST_OSC);
    COV_RTC_WAKE: cover property (@(posedge clk_i) disable iff (!resetn_i) rtc_wake);
    COV_RESUME: cover property (@(posedge clk_i) disable iff (!resetn_i)
        state_r == pdseq_pkg::ST_ISR ##1 state_r == pdseq_pkg::ST_RUN);
endmodule : power_down_sequencer

// ==== test/wake_pin_drv.sv ====
// wake pin driver model for the board side of the sequencer
// assumes go_i is a one-cycle pulse synchronous to clk_i
`timescale 1ns/1ps
module wake_pin_drv #(
    parameter int LOW = 12
) (
    // clock and request
    input  wire logic clk_i,
    input  wire logic go_i,
    // pin
    output logic      pin_o
);
    int cnt = 0;
    always_ff @(posedge clk_i) begin
        if (go_i) begin
            cnt <= LOW;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign pin_o = (cnt == 0);
endmodule : wake_pin_drv

// ==== test/testbench.sv ====
// self-checking bench for the power-down sequencer
// assumes a short wake qualifier count so the pin pulse stays brief
`timescale 1ns/1ps
`include "pdseq_consts.svh"
module testbench;
    logic        clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, go = 0, pin;
    logic        rtc_event_i = 0, osc_stable_i = 0, wake_return_i = 0;
    logic [3:0]  addr_i = 0;
    logic [7:0]  wr_data_i = 0, rd_data_o;
    logic [15:0] wake_vector_o;
    logic        cpu_halt_o, irq_mask_o, periph_freeze_o, wake_irq_o;
    logic        fetch_discard_o, osc_run_o, ale_o, display_off_o, latch = 1;
    logic        rtc_run_o, display_run_o, program_strobe_output_o, port0_float_o;
    logic        display_hold_o;
    int          miscompares = 0, cmp_count = 0, n;
    always #25 clk_i = ~clk_i;
    power_down_sequencer #(.WAKE_CNT(10)) u_power_down_sequencer (.clk_i, .resetn_i,
        .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .wake_pin_i(pin),
        .wake_latch_i(latch), .rtc_event_i, .osc_stable_i, .wake_return_i,
        .idle_i(1'b0), .ext_code_i(1'b0), .cpu_ale_i(1'b1), .cpu_strobe_i(1'b1),
        .cpu_halt_o, .irq_mask_o, .periph_freeze_o, .wake_irq_o, .wake_vector_o,
        .fetch_discard_o, .osc_run_o, .rtc_run_o, .display_run_o, .ale_o,
        .program_strobe_output_o, .port0_float_o, .display_hold_o,
        .display_off_o);
    wake_pin_drv u_wake_pin_drv (.clk_i, .go_i(go), .pin_o(pin));
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic report_and_stop;
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rd_data_o", {8'h00, rd_data_o}, {8'h00, e});
    endtask : rd
    // one-cycle pulse on a chosen strobe: 0 pin driver, 1 clock event, 2 return
    task automatic pulse(input int k);
        @(posedge clk_i);
        if (k == 0) go <= 1'b1; else if (k == 1) rtc_event_i <= 1'b1; else wake_return_i <= 1'b1;
        @(posedge clk_i);
        {go, rtc_event_i, wake_return_i} <= 3'h0;
        #1;
    endtask : pulse
    // no conversion running; arm and start back to back
    task automatic enter;
        @(posedge clk_i);
        addr_i <= 4'h0;
        wr_data_i <= 8'h02;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_data_i <= 8'h40;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1 chk("cpu_halt_o", cpu_halt_o, 1'b1);
    endtask : enter
    task automatic t_bits;
        rd(4'h4, 8'h08);
        rd(4'h7, 8'h00);
        wr(4'h1, 8'h80);
        rd(4'h1, 8'h00);
        wr(4'h0, 8'h02);
        rd(4'h0, 8'h00);
        wr(4'h0, 8'h42);
        #1 chk("cpu_halt_o", cpu_halt_o, 1'b0);
        rd(4'h0, 8'h00);
    endtask : t_bits
    task automatic t_nowake;
        enter();
        pulse(0);
        repeat (30) @(posedge clk_i);
        #1 chk("irq_mask_o", irq_mask_o, 1'b0);
        chk("ale_o", {ale_o, program_strobe_output_o, port0_float_o}, 3'h0);
        chk("osc_run_o", {osc_run_o, rtc_run_o}, 2'b00);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1 chk("osc_run_o", osc_run_o, 1'b1);
        rd(4'h4, 8'h08);
    endtask : t_nowake
    // clock event in run with wake armed for the clock source
    task automatic t_rtc_idle;
        wr(4'h4, 8'h01);
        pulse(1);
        chk("cpu_halt_o", {irq_mask_o, cpu_halt_o}, 2'b00);
        rd(4'h4, 8'h03);
    endtask : t_rtc_idle
    // wake source: 0 pin in mode one, 1 clock in mode three, 2 latch not one
    task automatic t_wake(input int src);
        wr(4'h2, 8'h10);
        wr(4'h1, (src == 1) ? 8'h90 : 8'h80);
        wr(4'h2, 8'h00);
        wr(4'h4, (src == 1) ? 8'h01 : 8'h08);
        latch <= (src != 2);
        enter();
        chk("rtc_run_o", {rtc_run_o, display_run_o}, (src == 1) ? 2'b10 : 2'b00);
        if (src == 1) chk("display_off_o", display_off_o, 1'b1);
        if (src != 2) pulse(0);
        if (src == 1) begin
            repeat (20) @(posedge clk_i);
            #1 chk("irq_mask_o", irq_mask_o, 1'b0);
            pulse(1);
        end
        for (n = 0; n < 40 && irq_mask_o !== 1'b1; n++) @(posedge clk_i) #1;
        chk("irq_mask_o", irq_mask_o, 1'b1);
        chk("periph_freeze_o", periph_freeze_o, 1'b1);
        chk("ale_o", {ale_o, program_strobe_output_o}, 2'b00);
        @(posedge clk_i);
        osc_stable_i <= 1'b1;
        #1 chk("wake_irq_o", wake_irq_o, 1'b1);
        for (n = 0; n < 40 && fetch_discard_o !== 1'b1; n++) @(posedge clk_i) #1;
        for (n = 0; n < 99 && fetch_discard_o === 1'b1; n++) @(posedge clk_i) #1;
        chk("call_len", 16'(n), `MCYCLE_CLKS * `CALL_MCYCLES);
        chk("wake_vector_o", wake_vector_o, `WAKE_VECTOR);
        chk("irq_mask_o", irq_mask_o, 1'b1);
        pulse(2);
        @(posedge clk_i);
        osc_stable_i <= 1'b0;
        latch <= 1'b1;
        @(posedge clk_i);
        #1 chk("periph_freeze_o", {periph_freeze_o, irq_mask_o, cpu_halt_o}, 3'h0);
    endtask : t_wake
    // display on, clock select, clock running
    task automatic t_mode2;
        wr(4'h3, 8'h03);
        wr(4'h4, 8'h00);
        enter();
        chk("display_hold_o", {display_hold_o, display_run_o, rtc_run_o}, 3'h7);
        rd(4'h5, 8'h51);
        chk("ale_o", {ale_o, program_strobe_output_o, display_off_o}, 3'h0);
    endtask : t_mode2
    initial begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_bits();
        t_nowake();
        t_wake(0);
        t_wake(2);
        t_wake(1);
        t_rtc_idle();
        t_mode2();
        report_and_stop();
    end
    // watchdog well beyond the expected run length
    initial begin
        #(5000 * `CLK_PERIOD_NS);
        miscompares++;
        report_and_stop();
    end
endmodule : testbench
